// >>> common/isl_pkg.sv
package isl_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int XLEN = 64;
  localparam int IDX_W = 7;
  localparam int IMM_W = 22;
  localparam int POS_W = 6;
  localparam int CNT_W = 2;
  localparam int EXT_W = 2;

  // ****************************************************************
  // immediate field widths
  // ****************************************************************
  localparam int IMM_ADD_W = 14;
  localparam int IMM_SUB_W = 8;
  localparam int IMM_LOG_W = 8;
  localparam int IMM_LONG_W = 22;

  // ****************************************************************
  // pointer layout
  // ****************************************************************
  localparam int PTR_W = 32;
  localparam int RGN_W = 2;
  localparam int RGN_SRC_LSB = 30;
  localparam int RGN_RES_LSB = 61;

  // ****************************************************************
  // register index limits
  // ****************************************************************
  localparam logic [IDX_W-1:0] ZERO_REG = 7'h00;
  localparam logic [IDX_W-1:0] LONG_SRC_MAX = 7'h03;

  // ****************************************************************
  // extension sizes
  // ****************************************************************
  localparam logic [EXT_W-1:0] EXT_BYTE = 2'h0;
  localparam logic [EXT_W-1:0] EXT_HALF = 2'h1;
  localparam logic [EXT_W-1:0] EXT_WORD = 2'h2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [XLEN-1:0] RES_RST = 64'h0000_0000_0000_0000;
  localparam logic [IDX_W-1:0] DST_RST = 7'h00;

  // ****************************************************************
  // operations
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_ADD, OP_ADD1, OP_SUB, OP_SUB1, OP_ADDL, OP_SHLADD,
    OP_AND, OP_OR, OP_XOR, OP_ANDCM,
    OP_ADDP, OP_SHLADDP, OP_SXT, OP_ZXT,
    OP_SHL, OP_SHR, OP_SHRU,
    OP_EXTR, OP_EXTRU, OP_DEP, OP_DEPZ, OP_DEPI, OP_DEPIZ,
    OP_SHRI, OP_SHRIU, OP_SHLI, OP_SHRP
  } isl_op_t;

  typedef enum logic [1:0] {
    BF_NONE, BF_EXTR, BF_DEP, BF_SHRP
  } isl_bf_t;

endpackage

// >>> verilog/isl_bitfield.sv
module isl_bitfield (
  // control
  input wire isl_pkg::isl_op_t bf_op,
  input wire logic bf_fill,
  input wire logic [isl_pkg::POS_W-1:0] bf_pos,
  input wire logic [isl_pkg::POS_W-1:0] bf_len_in,
  // data
  input wire logic [isl_pkg::XLEN-1:0] bf_src_in,
  input wire logic [isl_pkg::XLEN-1:0] bf_src_b,
  output logic [isl_pkg::XLEN-1:0] bf_res
);

  // ****************************************************************
  // extract, deposit and funnel shift
  // ****************************************************************
  logic [isl_pkg::XLEN-1:0] len_mask;
  logic [isl_pkg::XLEN-1:0] dep_mask;
  logic [isl_pkg::XLEN-1:0] shifted;
  logic [isl_pkg::XLEN-1:0] base;
  logic [2*isl_pkg::XLEN-1:0] pair;
  logic sign_bit;
  isl_pkg::isl_bf_t bf_mode;
  logic bf_signed;
  logic bf_zero_base;
  logic [isl_pkg::POS_W-1:0] bf_len_m1;
  logic [isl_pkg::XLEN-1:0] bf_src_a;

  always_comb begin
    bf_mode = isl_pkg::BF_NONE;
    bf_signed = 1'b0;
    bf_zero_base = 1'b0;
    bf_len_m1 = bf_len_in;
    bf_src_a = bf_src_in;
    case (bf_op)
      isl_pkg::OP_EXTR: begin
        bf_mode = isl_pkg::BF_EXTR;
        bf_signed = 1'b1;
      end
      isl_pkg::OP_EXTRU: begin
        bf_mode = isl_pkg::BF_EXTR;
      end
      isl_pkg::OP_SHRI: begin
        bf_mode = isl_pkg::BF_EXTR;
        bf_signed = 1'b1;
        bf_len_m1 = 6'h3f - bf_pos;
      end
      isl_pkg::OP_SHRIU: begin
        bf_mode = isl_pkg::BF_EXTR;
        bf_len_m1 = 6'h3f - bf_pos;
      end
      isl_pkg::OP_DEP: begin
        bf_mode = isl_pkg::BF_DEP;
      end
      isl_pkg::OP_DEPZ: begin
        bf_mode = isl_pkg::BF_DEP;
        bf_zero_base = 1'b1;
      end
      isl_pkg::OP_DEPI: begin
        bf_mode = isl_pkg::BF_DEP;
        bf_src_a = {isl_pkg::XLEN{bf_fill}};
      end
      isl_pkg::OP_DEPIZ: begin
        bf_mode = isl_pkg::BF_DEP;
        bf_zero_base = 1'b1;
        bf_src_a = {isl_pkg::XLEN{bf_fill}};
      end
      isl_pkg::OP_SHLI: begin
        bf_mode = isl_pkg::BF_DEP;
        bf_zero_base = 1'b1;
        bf_len_m1 = 6'h3f - bf_pos;
      end
      isl_pkg::OP_SHRP: begin
        bf_mode = isl_pkg::BF_SHRP;
      end
      default: begin
        bf_mode = isl_pkg::BF_NONE;
      end
    endcase
  end

  always_comb begin
    len_mask = {isl_pkg::XLEN{1'b1}} >> (6'h3f - bf_len_m1);
    dep_mask = len_mask << bf_pos;
    shifted = '0;
    base = '0;
    pair = '0;
    sign_bit = 1'b0;
    bf_res = '0;
    case (bf_mode)
      isl_pkg::BF_EXTR: begin
        if (bf_signed) begin
          shifted = $unsigned($signed(bf_src_a) >>> bf_pos);
        end else begin
          shifted = bf_src_a >> bf_pos;
        end
        sign_bit = shifted[bf_len_m1];
        bf_res = (shifted & len_mask) |
                 ((bf_signed && sign_bit) ? ~len_mask : '0);
      end
      isl_pkg::BF_DEP: begin
        base = bf_zero_base ? '0 : bf_src_b;
        bf_res = (base & ~dep_mask) |
                 ((bf_src_a << bf_pos) & dep_mask);
      end
      isl_pkg::BF_SHRP: begin
        pair = {bf_src_a, bf_src_b} >> bf_pos;
        bf_res = pair[isl_pkg::XLEN-1:0];
      end
      default: begin
        bf_res = '0;
      end
    endcase
  end

endmodule

// >>> verilog/isl_alu.sv
module isl_alu (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // integer-slot issue
  input wire logic i_valid,
  input wire isl_pkg::isl_op_t i_op,
  input wire logic [isl_pkg::IDX_W-1:0] i_src1_idx,
  input wire logic [isl_pkg::IDX_W-1:0] i_src2_idx,
  input wire logic [isl_pkg::IDX_W-1:0] i_dst_idx,
  input wire logic [isl_pkg::XLEN-1:0] i_src1,
  input wire logic [isl_pkg::XLEN-1:0] i_src2,
  input wire logic [isl_pkg::IMM_W-1:0] i_imm,
  input wire logic i_imm_sel,
  input wire logic [isl_pkg::CNT_W-1:0] i_cnt_m1,
  input wire logic [isl_pkg::EXT_W-1:0] i_ext,
  input wire logic [isl_pkg::POS_W-1:0] i_pos,
  input wire logic [isl_pkg::POS_W-1:0] i_len_m1,
  // integer-slot result
  output logic i_res_valid_q,
  output logic i_illegal_q,
  output logic [isl_pkg::IDX_W-1:0] i_dst_q,
  output logic [isl_pkg::XLEN-1:0] i_res_q,
  // memory-slot issue
  input wire logic m_valid,
  input wire isl_pkg::isl_op_t m_op,
  input wire logic [isl_pkg::IDX_W-1:0] m_src1_idx,
  input wire logic [isl_pkg::IDX_W-1:0] m_src2_idx,
  input wire logic [isl_pkg::IDX_W-1:0] m_dst_idx,
  input wire logic [isl_pkg::XLEN-1:0] m_src1,
  input wire logic [isl_pkg::XLEN-1:0] m_src2,
  input wire logic [isl_pkg::IMM_W-1:0] m_imm,
  input wire logic m_imm_sel,
  input wire logic [isl_pkg::CNT_W-1:0] m_cnt_m1,
  input wire logic [isl_pkg::EXT_W-1:0] m_ext,
  // memory-slot result
  output logic m_res_valid_q,
  output logic m_illegal_q,
  output logic [isl_pkg::IDX_W-1:0] m_dst_q,
  output logic [isl_pkg::XLEN-1:0] m_res_q
);

  // ****************************************************************
  // lane gathering
  // ****************************************************************
  localparam int LANES = 2;

  logic valid_w [LANES];
  isl_pkg::isl_op_t op_w [LANES];
  logic [isl_pkg::IDX_W-1:0] a_idx_w [LANES];
  logic [isl_pkg::IDX_W-1:0] b_idx_w [LANES];
  logic [isl_pkg::IDX_W-1:0] dst_w [LANES];
  logic [isl_pkg::XLEN-1:0] a_w [LANES];
  logic [isl_pkg::XLEN-1:0] b_w [LANES];
  logic [isl_pkg::IMM_W-1:0] imm_w [LANES];
  logic imm_sel_w [LANES];
  logic [isl_pkg::CNT_W-1:0] cnt_w [LANES];
  logic [isl_pkg::EXT_W-1:0] ext_w [LANES];

  logic res_valid_q [LANES];
  logic illegal_q [LANES];
  logic [isl_pkg::IDX_W-1:0] dst_q [LANES];
  logic [isl_pkg::XLEN-1:0] res_q [LANES];

  assign valid_w[0] = i_valid;
  assign op_w[0] = i_op;
  assign a_idx_w[0] = i_src1_idx;
  assign b_idx_w[0] = i_src2_idx;
  assign dst_w[0] = i_dst_idx;
  assign a_w[0] = i_src1;
  assign b_w[0] = i_src2;
  assign imm_w[0] = i_imm;
  assign imm_sel_w[0] = i_imm_sel;
  assign cnt_w[0] = i_cnt_m1;
  assign ext_w[0] = i_ext;

  assign valid_w[1] = m_valid;
  assign op_w[1] = m_op;
  assign a_idx_w[1] = m_src1_idx;
  assign b_idx_w[1] = m_src2_idx;
  assign dst_w[1] = m_dst_idx;
  assign a_w[1] = m_src1;
  assign b_w[1] = m_src2;
  assign imm_w[1] = m_imm;
  assign imm_sel_w[1] = m_imm_sel;
  assign cnt_w[1] = m_cnt_m1;
  assign ext_w[1] = m_ext;

  assign i_res_valid_q = res_valid_q[0];
  assign i_illegal_q = illegal_q[0];
  assign i_dst_q = dst_q[0];
  assign i_res_q = res_q[0];
  assign m_res_valid_q = res_valid_q[1];
  assign m_illegal_q = illegal_q[1];
  assign m_dst_q = dst_q[1];
  assign m_res_q = res_q[1];

  // ****************************************************************
  // per-lane datapath
  // ****************************************************************
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [isl_pkg::XLEN-1:0] opa;
    logic [isl_pkg::XLEN-1:0] opb;
    logic [isl_pkg::XLEN-1:0] imm_add;
    logic [isl_pkg::XLEN-1:0] imm_sub;
    logic [isl_pkg::XLEN-1:0] imm_log;
    logic [isl_pkg::XLEN-1:0] imm_long;
    logic [isl_pkg::XLEN-1:0] scaled;
    logic [isl_pkg::XLEN-1:0] arith_res;
    logic [isl_pkg::XLEN-1:0] logic_res;
    logic [isl_pkg::XLEN-1:0] ptr_sum;
    logic [isl_pkg::XLEN-1:0] ptr_res;
    logic [isl_pkg::XLEN-1:0] ext_res;
    logic [isl_pkg::XLEN-1:0] shift_res;
    logic [isl_pkg::XLEN-1:0] bf_res;
    logic [isl_pkg::XLEN-1:0] res_d;
    logic illegal_d;
    logic big_cnt;
    logic [isl_pkg::POS_W-1:0] amt;

    // ************************************************************
    // operand fetch and immediates
    // ************************************************************
    always_comb begin
      opa = (a_idx_w[g] == isl_pkg::ZERO_REG) ? '0 : a_w[g];
      opb = (b_idx_w[g] == isl_pkg::ZERO_REG) ? '0 : b_w[g];
      imm_add = 64'($signed(imm_w[g][isl_pkg::IMM_ADD_W-1:0]));
      imm_sub = 64'($signed(imm_w[g][isl_pkg::IMM_SUB_W-1:0]));
      imm_log = 64'($signed(imm_w[g][isl_pkg::IMM_LOG_W-1:0]));
      imm_long = 64'($signed(imm_w[g][isl_pkg::IMM_LONG_W-1:0]));
      scaled = opa << ({1'b0, cnt_w[g]} + 3'h1);
    end

    // ************************************************************
    // arithmetic
    // ************************************************************
    always_comb begin
      case (op_w[g])
        isl_pkg::OP_ADD: begin
          arith_res = (imm_sel_w[g] ? imm_add : opa) + opb;
        end
        isl_pkg::OP_ADD1: begin
          arith_res = opa + opb + 64'h0000_0000_0000_0001;
        end
        isl_pkg::OP_SUB: begin
          arith_res = (imm_sel_w[g] ? imm_sub : opa) - opb;
        end
        isl_pkg::OP_SUB1: begin
          arith_res = opa - opb - 64'h0000_0000_0000_0001;
        end
        isl_pkg::OP_ADDL: begin
          arith_res = imm_long + opb;
        end
        isl_pkg::OP_SHLADD: begin
          arith_res = scaled + opb;
        end
        default: begin
          arith_res = '0;
        end
      endcase
    end

    // ************************************************************
    // logical
    // ************************************************************
    always_comb begin
      case (op_w[g])
        isl_pkg::OP_AND: begin
          logic_res = (imm_sel_w[g] ? imm_log : opa) & opb;
        end
        isl_pkg::OP_OR: begin
          logic_res = (imm_sel_w[g] ? imm_log : opa) | opb;
        end
        isl_pkg::OP_XOR: begin
          logic_res = (imm_sel_w[g] ? imm_log : opa) ^ opb;
        end
        isl_pkg::OP_ANDCM: begin
          logic_res = (imm_sel_w[g] ? imm_log : opa) & ~opb;
        end
        default: begin
          logic_res = '0;
        end
      endcase
    end

    // ************************************************************
    // 32-bit pointers and widening
    // ************************************************************
    always_comb begin
      if (op_w[g] == isl_pkg::OP_SHLADDP) begin
        ptr_sum = scaled + opb;
      end else begin
        ptr_sum = (imm_sel_w[g] ? imm_add : opa) + opb;
      end
      ptr_res = '0;
      ptr_res[isl_pkg::PTR_W-1:0] = ptr_sum[isl_pkg::PTR_W-1:0];
      ptr_res[isl_pkg::RGN_RES_LSB +: isl_pkg::RGN_W] =
        opb[isl_pkg::RGN_SRC_LSB +: isl_pkg::RGN_W];
    end

    always_comb begin
      ext_res = '0;
      case (ext_w[g])
        isl_pkg::EXT_BYTE: begin
          ext_res[7:0] = opa[7:0];
          if (op_w[g] == isl_pkg::OP_SXT) begin
            ext_res = 64'($signed(opa[7:0]));
          end
        end
        isl_pkg::EXT_HALF: begin
          ext_res[15:0] = opa[15:0];
          if (op_w[g] == isl_pkg::OP_SXT) begin
            ext_res = 64'($signed(opa[15:0]));
          end
        end
        isl_pkg::EXT_WORD: begin
          ext_res[31:0] = opa[31:0];
          if (op_w[g] == isl_pkg::OP_SXT) begin
            ext_res = 64'($signed(opa[31:0]));
          end
        end
        default: begin
          ext_res = opa;
        end
      endcase
    end

    // ************************************************************
    // variable shifts
    // ************************************************************
    always_comb begin
      big_cnt = |opb[isl_pkg::XLEN-1:isl_pkg::POS_W];
      amt = opb[isl_pkg::POS_W-1:0];
      case (op_w[g])
        isl_pkg::OP_SHL: begin
          shift_res = big_cnt ? '0 : opa << amt;
        end
        isl_pkg::OP_SHR: begin
          if (big_cnt) begin
            shift_res = {isl_pkg::XLEN{opa[isl_pkg::XLEN-1]}};
          end else begin
            shift_res = $unsigned($signed(opa) >>> amt);
          end
        end
        isl_pkg::OP_SHRU: begin
          shift_res = big_cnt ? '0 : opa >> amt;
        end
        default: begin
          shift_res = '0;
        end
      endcase
    end

    // ************************************************************
    // bit-field unit, integer slot only
    // ************************************************************
    if (g == 0) begin : g_bf
      isl_bitfield u_bitfield (
        .bf_op(op_w[g]),
        .bf_fill(imm_w[g][0]),
        .bf_pos(i_pos),
        .bf_len_in(i_len_m1),
        .bf_src_in(opa),
        .bf_src_b(opb),
        .bf_res(bf_res)
      );
    end else begin : g_no_bf
      assign bf_res = '0;
    end

    // ************************************************************
    // result select and illegal forms
    // ************************************************************
    always_comb begin
      illegal_d = 1'b0;
      case (op_w[g])
        isl_pkg::OP_ADD, isl_pkg::OP_ADD1, isl_pkg::OP_SUB,
        isl_pkg::OP_SUB1, isl_pkg::OP_SHLADD: begin
          res_d = arith_res;
        end
        isl_pkg::OP_ADDL: begin
          res_d = arith_res;
          illegal_d = b_idx_w[g] > isl_pkg::LONG_SRC_MAX;
        end
        isl_pkg::OP_AND, isl_pkg::OP_OR, isl_pkg::OP_XOR,
        isl_pkg::OP_ANDCM: begin
          res_d = logic_res;
        end
        isl_pkg::OP_ADDP: begin
          res_d = ptr_res;
        end
        isl_pkg::OP_SHLADDP: begin
          res_d = ptr_res;
          illegal_d = imm_sel_w[g];
        end
        isl_pkg::OP_SXT, isl_pkg::OP_ZXT: begin
          res_d = ext_res;
          illegal_d = ext_w[g] > isl_pkg::EXT_WORD;
        end
        isl_pkg::OP_SHL, isl_pkg::OP_SHR, isl_pkg::OP_SHRU: begin
          res_d = (g == 0) ? shift_res : '0;
          illegal_d = (g != 0);
        end
        default: begin
          res_d = bf_res;
          illegal_d = (g != 0);
        end
      endcase
      if (illegal_d) begin
        res_d = '0;
      end
    end

    // ************************************************************
    // result registers
    // ************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        res_valid_q[g] <= 1'b0;
        illegal_q[g] <= 1'b0;
      end else begin
        res_valid_q[g] <= valid_w[g];
        illegal_q[g] <= valid_w[g] && illegal_d;
      end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        res_q[g] <= isl_pkg::RES_RST;
        dst_q[g] <= isl_pkg::DST_RST;
      end else if (valid_w[g]) begin
        res_q[g] <= res_d;
        dst_q[g] <= dst_w[g];
      end
    end
  end

endmodule

// >>> verification/isl_gr_model.sv
module isl_gr_model (
  // clock
  input wire logic clk,
  // preload from the bench
  input wire logic w_en,
  input wire logic [6:0] w_idx [2],
  input wire logic [63:0] w_val [2],
  // operand reads
  input wire logic [6:0] rd_idx [2],
  output logic [63:0] rd_val [2]
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // register file
  // ****************************************************************
  logic [63:0] gr_q [128];
  always_ff @(posedge clk) begin
    if (w_en) begin
      for (int k = 0; k < 2; k++) begin
        gr_q[w_idx[k]] <= w_val[k];
      end
    end
  end
  // register zero reads zero whatever was written
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      rd_val[k] = (rd_idx[k] == 7'h00) ? 64'h0 : gr_q[rd_idx[k]];
    end
  end
endmodule

// >>> verification/isl_alu_properties.sv
module isl_alu_props (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // integer slot
  input wire logic i_valid,
  input wire isl_pkg::isl_op_t i_op,
  input wire logic [6:0] i_src1_idx,
  input wire logic [6:0] i_src2_idx,
  input wire logic [6:0] i_dst_idx,
  input wire logic [63:0] i_src1,
  input wire logic [63:0] i_src2,
  input wire logic i_imm_sel,
  input wire logic [5:0] i_pos,
  input wire logic i_res_valid_q,
  input wire logic i_illegal_q,
  input wire logic [6:0] i_dst_q,
  input wire logic [63:0] i_res_q,
  // memory slot
  input wire logic m_valid,
  input wire isl_pkg::isl_op_t m_op,
  input wire logic [63:0] m_src1,
  input wire logic [63:0] m_src2,
  input wire logic m_imm_sel,
  input wire logic m_res_valid_q,
  input wire logic m_illegal_q,
  input wire logic [63:0] m_res_q
);
  // ****************************************************************
  // operand capture
  // ****************************************************************
  logic [63:0] a_q, b_q, ma_q, mb_q;
  logic [5:0] p_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      a_q <= 64'h0;
      b_q <= 64'h0;
      ma_q <= 64'h0;
      mb_q <= 64'h0;
      p_q <= 6'h0;
    end else begin
      a_q <= i_src1;
      b_q <= i_src2;
      ma_q <= m_src1;
      mb_q <= m_src2;
      p_q <= i_pos;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_i(isl_pkg::isl_op_t o);
    i_valid && i_op == o && !i_imm_sel && i_src1_idx != 7'h00
      && i_src2_idx != 7'h00;
  endsequence
  // ****************************************************************
  // checks
  // ****************************************************************
  AST_LAT: assert property (i_valid |=> i_res_valid_q
    && i_dst_q == $past(i_dst_idx)) else $error("late result");
  AST_IDLE: assert property (!i_valid |=> !i_res_valid_q
    && $stable(i_res_q)) else $error("result without op");
  AST_M_LAT: assert property (m_valid |=> m_res_valid_q)
    else $error("memory slot late");
  AST_M_AND: assert property (m_valid && m_op == isl_pkg::OP_AND
    && !m_imm_sel |=> !m_illegal_q && m_res_q == (ma_q & mb_q))
    else $error("memory slot and wrong");
  AST_ADD1: assert property (s_i(isl_pkg::OP_ADD1)
    |=> i_res_q == a_q + b_q + 64'h1) else $error("add one wrong");
  AST_SUB1: assert property (s_i(isl_pkg::OP_SUB1)
    |=> i_res_q == a_q - b_q - 64'h1) else $error("sub one wrong");
  AST_ANDCM: assert property (s_i(isl_pkg::OP_ANDCM)
    |=> i_res_q == (a_q & ~b_q)) else $error("mask clear wrong");
  AST_ADDP: assert property (s_i(isl_pkg::OP_ADDP) |=> i_res_q ==
    {1'b0, b_q[31:30], 29'h0, a_q[31:0] + b_q[31:0]})
    else $error("pointer sum wrong");
  AST_ROT: assert property (s_i(isl_pkg::OP_SHRP)
    ##0 i_src1_idx == i_src2_idx
    |=> i_res_q == ((a_q >> p_q) | (a_q << (7'h40 - p_q))))
    else $error("rotate wrong");
  AST_SHL_BIG: assert property (s_i(isl_pkg::OP_SHL)
    ##0 i_src2[63:6] != 58'h0 |=> i_res_q == 64'h0)
    else $error("large shift not zero");
  AST_ADDL_ILL: assert property (i_valid
    && i_op == isl_pkg::OP_ADDL && i_src2_idx > isl_pkg::LONG_SRC_MAX
    |=> i_illegal_q && i_res_q == 64'h0) else $error("long add legal");
  AST_ILL: assert property (i_illegal_q |-> i_res_valid_q)
    else $error("illegal flag alone");
endmodule

bind isl_alu isl_alu_props u_isl_alu_props (.clk(clk), .sys_rst(sys_rst),
  .i_valid(i_valid), .i_op(i_op), .i_src1_idx(i_src1_idx),
  .i_src2_idx(i_src2_idx), .i_dst_idx(i_dst_idx), .i_src1(i_src1),
  .i_src2(i_src2), .i_imm_sel(i_imm_sel), .i_pos(i_pos),
  .i_res_valid_q(i_res_valid_q), .i_illegal_q(i_illegal_q),
  .i_dst_q(i_dst_q), .i_res_q(i_res_q), .m_valid(m_valid), .m_op(m_op),
  .m_src1(m_src1), .m_src2(m_src2), .m_imm_sel(m_imm_sel),
  .m_res_valid_q(m_res_valid_q), .m_illegal_q(m_illegal_q),
  .m_res_q(m_res_q));

// >>> verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk, sys_rst, i_valid, m_valid, sl, w_en, i_rv, i_il, m_rv, m_il;
  isl_pkg::isl_op_t op;
  logic [6:0] dst, i_dq, m_dq, x_ib, rd_idx [2], w_idx [2];
  logic [63:0] va, vb, i_rq, m_rq, rd_val [2], w_val [2];
  logic [21:0] im;
  logic [1:0] c;
  logic [5:0] ps, ln, x_ps, x_ln;
  int n_fail, samples_checked, cyc;
  isl_alu u_isl_alu (.clk(clk), .sys_rst(sys_rst), .i_valid(i_valid),
    .i_op(op), .i_src1_idx(rd_idx[0]), .i_src2_idx(rd_idx[1]),
    .i_dst_idx(dst), .i_src1(rd_val[0]), .i_src2(rd_val[1]), .i_imm(im),
    .i_imm_sel(sl), .i_cnt_m1(c), .i_ext(c), .i_pos(ps), .i_len_m1(ln),
    .i_res_valid_q(i_rv), .i_illegal_q(i_il), .i_dst_q(i_dq),
    .i_res_q(i_rq), .m_valid(m_valid), .m_op(op), .m_src1_idx(rd_idx[0]),
    .m_src2_idx(rd_idx[1]), .m_dst_idx(dst), .m_src1(rd_val[0]),
    .m_src2(rd_val[1]), .m_imm(im), .m_imm_sel(sl), .m_cnt_m1(c),
    .m_ext(c), .m_res_valid_q(m_rv), .m_illegal_q(m_il), .m_dst_q(m_dq),
    .m_res_q(m_rq));
  isl_gr_model u_isl_gr_model (.clk(clk), .w_en(w_en), .w_idx(w_idx),
    .w_val(w_val), .rd_idx(rd_idx), .rd_val(rd_val));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      complete_run();
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // preload operands, issue one op, judge the answer one edge later
  task automatic run(input isl_pkg::isl_op_t o, input logic [63:0] ex,
    input logic [21:0] i = 22'h0, input logic s = 1'b0,
    input logic [1:0] k = 2'h0, input logic il = 1'b0,
    input logic ml = 1'b0);
    logic ok;
    @(posedge clk);
    w_en <= 1'b1;
    w_val[0] <= va;
    w_val[1] <= vb;
    w_idx[1] <= x_ib;
    @(posedge clk);
    w_en <= 1'b0;
    i_valid <= !ml;
    m_valid <= ml;
    op <= o;
    dst <= {2'h0, o};
    rd_idx[1] <= x_ib;
    im <= i;
    sl <= s;
    c <= k;
    ps <= x_ps;
    ln <= x_ln;
    @(posedge clk);
    i_valid <= 1'b0;
    m_valid <= 1'b0;
    #1;
    ok = ml ? (m_rv === 1'b1 && i_rv === 1'b0 && m_il === il
      && m_rq === ex && m_dq === {2'h0, o})
      : (i_rv === 1'b1 && m_rv === 1'b0 && i_il === il
      && i_rq === ex && i_dq === {2'h0, o});
    samples_checked++;
    if (!ok) begin
      n_fail++;
      $display("MISMATCH %0t op %s", $time, o.name());
    end
  endtask
  function automatic logic [63:0] ptr(input logic [63:0] a, b);
    ptr = {1'b0, b[31:30], 29'h0, a[31:0] + b[31:0]};
  endfunction
  task automatic t_arith();
    run(isl_pkg::OP_ADD1, va + vb + 64'h1);
    run(isl_pkg::OP_SUB1, va - vb - 64'h1);
    run(isl_pkg::OP_ADD, vb - 64'h2000, 22'h3F_2000, 1);
    run(isl_pkg::OP_SUB, -64'h80 - vb, 22'h00_0180, 1);
    run(isl_pkg::OP_SHLADD, (va << 1) + vb);
    run(isl_pkg::OP_SHLADD, (va << 4) + vb, 0, 0, 2'h3);
    x_ib = 7'h03;
    run(isl_pkg::OP_ADDL, vb - 64'h1F_FFFF, 22'h20_0001);
    x_ib = 7'h00;
    run(isl_pkg::OP_ADDL, 64'h0000_0000_001F_FFFF, 22'h1F_FFFF);
    x_ib = 7'h04;
    run(isl_pkg::OP_ADDL, 64'h0, 22'h1, 0, 0, 1);
    x_ib = 7'h02;
    $display("arithmetic done");
  endtask
  task automatic t_logic();
    for (int l = 0; l < 2; l++) begin
      run(isl_pkg::OP_AND, va & vb, 0, 0, 0, 0, l[0]);
      run(isl_pkg::OP_OR, -64'h7F | vb, 22'h181, 1, 0, 0, l[0]);
      run(isl_pkg::OP_XOR, va ^ vb, 0, 0, 0, 0, l[0]);
      run(isl_pkg::OP_ANDCM, va & ~vb, 0, 0, 0, 0, l[0]);
      run(isl_pkg::OP_ANDCM, 64'h55 & ~vb, 22'h55, 1, 0, 0, l[0]);
      run(isl_pkg::OP_ADDP, ptr(va, vb), 0, 0, 0, 0, l[0]);
    end
    $display("logic done");
  endtask
  task automatic t_ptr();
    run(isl_pkg::OP_ADDP, ptr(-64'h2000, vb), 22'h2000, 1);
    run(isl_pkg::OP_SHLADDP, ptr(va << 3, vb), 0, 0, 2'h2);
    run(isl_pkg::OP_SHLADDP, 64'h0, 0, 1, 0, 1);
    run(isl_pkg::OP_SXT, {{56{va[7]}}, va[7:0]}, 0, 0, 2'h0);
    run(isl_pkg::OP_ZXT, {48'h0, va[15:0]}, 0, 0, 2'h1);
    run(isl_pkg::OP_SXT, {{32{va[31]}}, va[31:0]}, 0, 0, 2'h2);
    run(isl_pkg::OP_ZXT, {32'h0, va[31:0]}, 0, 0, 2'h2);
    run(isl_pkg::OP_SXT, 64'h0, 0, 0, 2'h3, 1);
    $display("pointer and widen done");
  endtask
  task automatic t_shift();
    vb = 64'h13;
    run(isl_pkg::OP_SHL, va << 19);
    run(isl_pkg::OP_SHR, $signed(va) >>> 19);
    run(isl_pkg::OP_SHRU, va >> 19);
    vb = 64'h40;
    run(isl_pkg::OP_SHL, 64'h0);
    run(isl_pkg::OP_SHR, {64{va[63]}});
    run(isl_pkg::OP_SHRU, 64'h0, 0, 0, 0, 1, 1);
    vb = 64'h0F00_0000_8000_0013;
    $display("shift done");
  endtask
  task automatic t_field();
    logic [127:0] w;
    x_ps = 6'h04;
    x_ln = 6'h07;
    run(isl_pkg::OP_EXTR, {{56{va[11]}}, va[11:4]});
    run(isl_pkg::OP_EXTRU, {56'h0, va[11:4]});
    run(isl_pkg::OP_DEP, (vb & ~64'hFF0) | {52'h0, va[7:0], 4'h0});
    run(isl_pkg::OP_DEPZ, {52'h0, va[7:0], 4'h0});
    run(isl_pkg::OP_DEPI, vb | 64'hFF0, 22'h1);
    run(isl_pkg::OP_DEPIZ, 64'hFF0, 22'h1);
    x_ps = 6'h0C;
    run(isl_pkg::OP_SHRI, $signed(va) >>> 12);
    run(isl_pkg::OP_SHRIU, va >> 12);
    run(isl_pkg::OP_SHLI, va << 12);
    w = {va, vb} >> 12;
    run(isl_pkg::OP_SHRP, w[63:0]);
    x_ps = 6'h3F;
    w = {va, vb} >> 63;
    run(isl_pkg::OP_SHRP, w[63:0]);
    x_ib = 7'h01;
    run(isl_pkg::OP_SHRP, (vb >> 63) | (vb << 1));
    x_ib = 7'h02;
    $display("bit field done");
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {sys_rst, i_valid, m_valid, sl, w_en} = 5'b10000;
    op = isl_pkg::OP_ADD;
    {dst, im, c, ps, ln, x_ps, x_ln} = '0;
    rd_idx[0] = 7'h01;
    rd_idx[1] = 7'h02;
    w_idx[0] = 7'h01;
    w_idx[1] = 7'h02;
    w_val[0] = 64'h0;
    w_val[1] = 64'h0;
    x_ib = 7'h02;
    va = 64'h8123_4567_89AB_CDEF;
    vb = 64'h0F00_0000_8000_0013;
    {n_fail, samples_checked, cyc} = '0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_arith();
    t_logic();
    t_ptr();
    t_shift();
    t_field();
    complete_run();
  end
endmodule
